// ### idu_divcore.sv
`timescale 1ns/1ps
// Purpose: Unsigned restoring divider, one quotient bit per cycle
// Assumes: Operands held stable by the caller only at start
// Notes: Dividend sits in the top bits; count gives the number of steps
module idu_divcore (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [6:0] bitCount,
    input wire logic [127:0] dividend,
    input wire logic [63:0] divisor,
    // Results
    output logic busy,
    output logic done,
    output logic [127:0] quotient,
    output logic [64:0] remainder
);
    import idu_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [6:0] cnt;
        logic [127:0] quo;
        logic [64:0] rem;
        logic [63:0] dsr;
    } idu_core_s;

    idu_core_s state_q, state_d;
    logic [64:0] trial;

    // One shift-subtract step per cycle
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        trial = '0;
        if (start) begin
            state_d.busy = 1'b1;
            state_d.cnt = bitCount;
            state_d.quo = dividend;
            state_d.rem = '0;
            state_d.dsr = divisor;
        end else if (state_q.busy) begin
            trial = {state_q.rem[63:0], state_q.quo[127]};
            state_d.quo = {state_q.quo[126:0], 1'b0};
            if (trial >= {1'b0, state_q.dsr}) begin
                state_d.rem = trial - {1'b0, state_q.dsr};
                state_d.quo[0] = 1'b1;
            end else begin
                state_d.rem = trial;
            end
            state_d.cnt = state_q.cnt - 7'h01;
            if (state_q.cnt == 7'h01) begin
                state_d.busy = 1'b0;
                state_d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign busy = state_q.busy;
    assign done = state_q.done;
    assign quotient = state_q.quo;
    assign remainder = state_q.rem;
endmodule

// ### idu_divide_chk.sv
// Purpose: Port-level checks for the integer divide unit
// Assumes: Sees only the top-level ports, one clock domain
// Notes: Accepted request fields are kept to judge the answer
`timescale 1ns/1ps
module idu_divide_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration and issue
    input wire logic is64BitImpl,
    input wire logic reqValid,
    input wire idu_pkg::idu_req_s req,
    input wire logic reqReady,
    // Writeback
    input wire logic rspValid,
    input wire idu_pkg::idu_rsp_s rsp
);
    import idu_pkg::*;
    logic take;
    logic longOp;
    logic oeQ, rcQ, zeroDivQ, badOpQ;
    // Request accepted and 64-bit opcode decode
    assign take = reqValid && reqReady;
    assign longOp = (req.extOp == IDU_XO_DIVD) || (req.extOp == IDU_XO_DIVDU);
    // Keep fields of the accepted request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oeQ <= 1'b0;
            rcQ <= 1'b0;
            zeroDivQ <= 1'b0;
            badOpQ <= 1'b0;
        end else if (take) begin
            oeQ <= req.overflowEnable;
            rcQ <= req.recordBit;
            zeroDivQ <= is64BitImpl && longOp && (req.secondSource == 64'h0);
            badOpQ <= !is64BitImpl && longOp;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_drops: assert property (take |=> !reqReady) else $error("ready stayed high after take");
    a_answer_bounded: assert property (take |-> ##[1:80] rspValid) else $error("no answer in time");
    a_rsp_pulse: assert property (rspValid |=> !rspValid && reqReady) else $error("answer not one cycle");
    a_rsp_stands: assert property (!rspValid |-> $stable(rsp)) else $error("result changed between answers");
    a_xer_follow: assert property (rspValid && !rsp.illegal |-> rsp.updXer == oeQ)
        else $error("exception update differs from enable");
    a_cr_follow: assert property (rspValid && !rsp.illegal |-> rsp.updCr0 == rcQ)
        else $error("condition update differs from record");
    a_sticky_copy: assert property (rspValid && rsp.updXer |-> rsp.stickyOverflow == rsp.arithExcess)
        else $error("sticky differs from excess");
    a_sign_flags: assert property (rspValid && rsp.updCr0 && !rsp.arithExcess |->
        {rsp.belowZero, rsp.aboveZero, rsp.zeroResult} ==
        {rsp.target[63], !rsp.target[63] && (rsp.target != 64'h0), rsp.target == 64'h0})
        else $error("compare flags wrong");
    a_zero_excess: assert property (rspValid && zeroDivQ && oeQ |-> rsp.arithExcess)
        else $error("divide by zero without excess");
    a_illegal_op: assert property (rspValid && badOpQ |-> rsp.illegal && !rsp.updXer && !rsp.updCr0)
        else $error("64-bit op not refused");
endmodule

// ### idu_divide_unit.sv
`timescale 1ns/1ps
// Purpose: Integer divide unit for long, unsigned, short and extended divides
// Assumes: Decode holds req stable only in the issue cycle; one op in flight
// Notes: Results, extension and flags appear together on a one-cycle valid
module idu_divide_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic is64BitImpl,
    // Issue
    input wire logic reqValid,
    input wire idu_pkg::idu_req_s req,
    output logic reqReady,
    // Writeback
    output logic rspValid,
    output idu_pkg::idu_rsp_s rsp
);
    import idu_pkg::*;

    typedef enum logic [1:0] {IDU_IDLE, IDU_RUN, IDU_WAIT, IDU_FINISH} idu_state_e;

    typedef struct packed {
        idu_state_e fsm;
        idu_op_e op;
        logic oe;
        logic rc;
        logic negQuo;
        logic negRem;
        logic special;
        logic startCore;
        logic [127:0] dividend;
        logic [63:0] divisor;
        logic [6:0] count;
        logic ready;
        logic rspValid;
        idu_rsp_s rsp;
        idu_rsp_s work;
    } idu_top_s;

    idu_top_s state_q, state_d;
    logic coreBusy;
    logic coreDone;
    logic [127:0] coreQuo;
    logic [64:0] coreRem;
    logic [63:0] q64;
    logic [63:0] r64;
    logic ovf;
    logic [63:0] magA;
    logic [63:0] magB;
    logic [63:0] wA;
    logic [63:0] wB;
    logic [127:0] extDividend;

    // Two's complement magnitude, used on every signed operand and result
    function automatic logic [63:0] idu_abs(input logic [63:0] v, input logic neg);
        idu_abs = neg ? (~v + 64'h1) : v;
    endfunction

    // Sign compare of a result against zero
    function automatic logic [2:0] idu_cmp(input logic [63:0] v);
        idu_cmp = {v[63], (!v[63]) && (v != 64'h0), v == 64'h0};
    endfunction

    idu_divcore u_core (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(state_q.startCore),
        .bitCount(state_q.count),
        .dividend(state_q.dividend),
        .divisor(state_q.divisor),
        .busy(coreBusy),
        .done(coreDone),
        .quotient(coreQuo),
        .remainder(coreRem)
    );

    // Sign-extended word operands and extended dividend
    always_comb begin
        wA = {{32{req.firstSource[31]}}, req.firstSource[31:0]};
        wB = {{32{req.secondSource[31]}}, req.secondSource[31:0]};
        extDividend = {{64{req.firstSource[31]}}, req.firstSource[31:0], req.quotExt[31:0]};
        magA = idu_abs(wA, wA[63]);
        magB = idu_abs(wB, wB[63]);
    end

    // Sign fix-up of the unsigned core results
    always_comb begin
        q64 = idu_abs(coreQuo[63:0], state_q.negQuo);
        r64 = idu_abs(coreRem[63:0], state_q.negRem);
        ovf = 1'b0;
        if (state_q.op == IDU_OP_DIVS || state_q.op == IDU_OP_DIVX) begin
            // Word quotient must fit 32 signed bits
            ovf = (q64[63:31] != {33{q64[31]}});
            if (coreQuo[127:64] != 64'h0) begin
                ovf = 1'b1;
            end
        end
        if (q64 == 64'h0) begin
            r64 = idu_abs(coreRem[63:0], 1'b0) == 64'h0 ? 64'h0 : r64;
        end
    end

    // Issue, sequencing and writeback
    always_comb begin
        state_d = state_q;
        state_d.startCore = 1'b0;
        state_d.rspValid = 1'b0;
        case (state_q.fsm)
            IDU_IDLE: begin
                state_d.ready = 1'b1;
                if (reqValid && state_q.ready) begin
                    state_d.ready = 1'b0;
                    state_d.oe = req.overflowEnable;
                    state_d.rc = req.recordBit;
                    state_d.work = '0;
                    state_d.special = 1'b0;
                    state_d.fsm = IDU_RUN;
                    if (req.primaryOp != IDU_PRIMARY_OP) begin
                        state_d.work.illegal = 1'b1;
                        state_d.fsm = IDU_FINISH;
                    end else begin
                        case (req.extOp)
                            IDU_XO_DIVD: begin
                                state_d.op = IDU_OP_DIVD;
                                state_d.negQuo = req.firstSource[63] ^ req.secondSource[63];
                                state_d.negRem = req.firstSource[63];
                                // Magnitude in the top bits, the core shifts MSB first
                                state_d.dividend = {idu_abs(req.firstSource, req.firstSource[63]), 64'h0};
                                state_d.divisor = idu_abs(req.secondSource, req.secondSource[63]);
                                state_d.count = IDU_CNT_LONG;
                                // Most negative over minus one, or zero divisor
                                state_d.special = (req.secondSource == 64'h0) ||
                                    (req.firstSource == {1'b1, 63'h0} && req.secondSource == '1);
                            end
                            IDU_XO_DIVDU: begin
                                state_d.op = IDU_OP_DIVDU;
                                state_d.negQuo = 1'b0;
                                state_d.negRem = 1'b0;
                                state_d.dividend = {req.firstSource, 64'h0};
                                state_d.divisor = req.secondSource;
                                state_d.count = IDU_CNT_LONG;
                                state_d.special = (req.secondSource == 64'h0);
                            end
                            IDU_XO_DIVS: begin
                                state_d.op = IDU_OP_DIVS;
                                state_d.negQuo = wA[63] ^ wB[63];
                                state_d.negRem = wA[63];
                                state_d.dividend = {magA[31:0], 96'h0};
                                state_d.divisor = magB;
                                state_d.count = IDU_CNT_SHORT;
                                state_d.special = (wB == 64'h0);
                            end
                            IDU_XO_DIVX: begin
                                state_d.op = IDU_OP_DIVX;
                                state_d.negQuo = extDividend[63] ^ wB[63];
                                state_d.negRem = extDividend[63];
                                state_d.dividend = {idu_abs(extDividend[63:0], extDividend[63]), 64'h0};
                                state_d.divisor = magB;
                                state_d.count = IDU_CNT_EXT;
                                state_d.special = (wB == 64'h0);
                            end
                            default: begin
                                state_d.work.illegal = 1'b1;
                                state_d.fsm = IDU_FINISH;
                            end
                        endcase
                        // Long divides exist only on 64-bit parts
                        if ((req.extOp == IDU_XO_DIVD || req.extOp == IDU_XO_DIVDU) && !is64BitImpl) begin
                            state_d.work.illegal = 1'b1;
                            state_d.fsm = IDU_FINISH;
                        end
                    end
                end
            end
            IDU_RUN: begin
                state_d.startCore = 1'b1;
                state_d.fsm = IDU_WAIT;
            end
            IDU_WAIT: begin
                if (coreDone) begin
                    // Results gather in the work copy; the output moves only at finish
                    state_d.work.target = q64;
                    state_d.work.quotExt = r64;
                    state_d.work.wrQuotExt = (state_q.op == IDU_OP_DIVS) || (state_q.op == IDU_OP_DIVX);
                    state_d.work.arithExcess = state_q.special || ovf;
                    if ((state_q.op == IDU_OP_DIVS || state_q.op == IDU_OP_DIVX) &&
                        !state_q.special && q64 == 64'h80000000) begin
                        // Minus two to the 31st over minus one
                        state_d.work.target = {{32{1'b1}}, 32'h80000000};
                        state_d.work.quotExt = 64'h0;
                    end
                    if (state_q.special) begin
                        state_d.work.target = 64'h0;
                        state_d.work.quotExt = 64'h0;
                    end
                    state_d.fsm = IDU_FINISH;
                end
            end
            IDU_FINISH: begin
                // Sticky flag and copy follow excess; carry never touched
                state_d.rsp = state_q.work;
                state_d.rsp.updXer = state_q.oe && !state_q.work.illegal;
                state_d.rsp.stickyOverflow = state_q.work.arithExcess;
                state_d.rsp.updCr0 = state_q.rc && !state_q.work.illegal;
                {state_d.rsp.belowZero, state_d.rsp.aboveZero, state_d.rsp.zeroResult} =
                    idu_cmp(state_q.work.target);
                state_d.rsp.crSticky = state_q.work.arithExcess;
                state_d.rspValid = 1'b1;
                state_d.fsm = IDU_IDLE;
            end
            default: begin
                state_d.fsm = IDU_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reqReady = state_q.ready;
    assign rspValid = state_q.rspValid;
    assign rsp = state_q.rsp;
endmodule

// ### idu_issue_model.sv
// Purpose: Decode-stage model issuing divide requests
// Assumes: Caller pulses go only when the unit is ready
// Notes: Holds the request until taken, captures each answer
`timescale 1ns/1ps
module idu_issue_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench side
    input wire logic go,
    input wire idu_pkg::idu_req_s goReq,
    output idu_pkg::idu_rsp_s got,
    output int rspCnt,
    // Unit side
    input wire logic reqReady,
    input wire logic rspValid,
    input wire idu_pkg::idu_rsp_s rsp,
    output logic reqValid,
    output idu_pkg::idu_req_s req
);
    import idu_pkg::*;
    // Request held until the take edge, answer captured on its pulse
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reqValid <= 1'b0;
            req <= '0;
            rspCnt <= 0;
        end else begin
            if (reqValid && reqReady) begin
                reqValid <= 1'b0;
                req <= ~req;
            end else if (go) begin
                reqValid <= 1'b1;
                req <= goReq;
            end
            if (rspValid) begin
                got <= rsp;
                rspCnt <= rspCnt + 1;
            end
        end
    end
endmodule

// ### idu_pkg.sv
// Purpose: Shared constants and types for the integer divide unit
// Assumes: One processor clock, synchronous active-low reset
// Notes: Opcode and field values as decoded by the issue stage
package idu_pkg;
    localparam int unsigned IDU_XLEN = 64;
    localparam int unsigned IDU_WLEN = 32;
    localparam logic [5:0] IDU_PRIMARY_OP = 6'h1f;
    localparam logic [8:0] IDU_XO_DIVD = 9'h1e9;   // 489
    localparam logic [8:0] IDU_XO_DIVDU = 9'h1c9;  // 457
    localparam logic [8:0] IDU_XO_DIVS = 9'h16b;   // 363
    localparam logic [8:0] IDU_XO_DIVX = 9'h14b;   // 331
    localparam logic [6:0] IDU_CNT_LONG = 7'h40;
    localparam logic [6:0] IDU_CNT_SHORT = 7'h20;
    localparam logic [6:0] IDU_CNT_EXT = 7'h40;

    typedef enum logic [1:0] {IDU_OP_DIVD, IDU_OP_DIVDU, IDU_OP_DIVS, IDU_OP_DIVX} idu_op_e;

    // Instruction request from decode
    typedef struct packed {
        logic [5:0] primaryOp;
        logic [8:0] extOp;
        logic overflowEnable;
        logic recordBit;
        logic [63:0] firstSource;
        logic [63:0] secondSource;
        logic [63:0] quotExt;
    } idu_req_s;

    // Result bundle written back together
    typedef struct packed {
        logic [63:0] target;
        logic wrQuotExt;
        logic [63:0] quotExt;
        logic updXer;
        logic stickyOverflow;
        logic arithExcess;
        logic updCr0;
        logic belowZero;
        logic aboveZero;
        logic zeroResult;
        logic crSticky;
        logic illegal;
    } idu_rsp_s;
endpackage

// ### integer_divide_unit_tb.sv
// Purpose: Self-checking bench for the integer divide unit
// Assumes: 125 MHz clock, synchronous active-low reset
// Notes: Expected values worked out from the divide rules
`timescale 1ns/1ps
module integer_divide_unit_tb;
    import idu_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic is64BitImpl = 1'b1;
    logic go = 1'b0;
    idu_req_s goReq = '0;
    logic reqValid, reqReady, rspValid;
    idu_req_s req;
    idu_rsp_s rsp, got;
    int rspCnt;
    int n_errors = 0;
    int n_compared = 0;
    // Clock
    always #4 ref_clk = ~ref_clk;
    idu_divide_unit uut (.ref_clk(ref_clk), .rst_n(rst_n), .is64BitImpl(is64BitImpl), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp));
    idu_issue_model issuer (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .goReq(goReq), .got(got),
        .rspCnt(rspCnt), .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp), .reqValid(reqValid), .req(req));
    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One divide: wait ready, issue, wait for the answer
    task automatic issue(input logic [8:0] xo, input logic oe, input logic rc, input logic [63:0] a,
        input logic [63:0] b, input logic [63:0] mq);
        int n;
        int startCnt;
        n = 0;
        startCnt = rspCnt;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (reqReady !== 1'b1 && n < 300);
        @(posedge ref_clk);
        goReq <= '{IDU_PRIMARY_OP, xo, oe, rc, a, b, mq};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (rspCnt == startCnt && n < 300);
        if (n >= 300) begin
            n_errors++;
        end
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        issue(IDU_XO_DIVD, 1'b0, 1'b1, 64'h7, 64'hffff_ffff_ffff_fffe, 64'h0);
        chk(got.target, 64'hffff_ffff_ffff_fffd, "signed quotient");
        chk({60'h0, got.updCr0, got.belowZero, got.aboveZero, got.zeroResult}, 64'hc, "record flags");
        chk(got.wrQuotExt, 64'h0, "no remainder write");
        issue(IDU_XO_DIVD, 1'b1, 1'b0, 64'h8000_0000_0000_0000, 64'hffff_ffff_ffff_ffff, 64'h0);
        chk(got.arithExcess, 64'h1, "signed overflow");
        chk(got.target, 64'h0, "overflow target");
        issue(IDU_XO_DIVD, 1'b0, 1'b0, 64'hffff_ffff_ffff_fff9, 64'h2, 64'h0);
        chk(got.target, 64'hffff_ffff_ffff_fffd, "negative dividend");
        issue(IDU_XO_DIVDU, 1'b0, 1'b1, 64'hffff_ffff_ffff_ffff, 64'h1, 64'h0);
        chk(got.target, 64'hffff_ffff_ffff_ffff, "unsigned quotient");
        chk(got.belowZero, 64'h1, "unsigned below flag");
        issue(IDU_XO_DIVDU, 1'b1, 1'b1, 64'h5, 64'h0, 64'h0);
        chk(got.arithExcess, 64'h1, "unsigned zero divisor");
        chk(got.updXer, 64'h1, "unsigned exception update");
        chk(got.crSticky, 64'h1, "record sticky copy");
        issue(IDU_XO_DIVDU, 1'b0, 1'b0, 64'h5, 64'h0, 64'h0);
        chk(got.updXer, 64'h0, "enable clear");
        issue(IDU_XO_DIVS, 1'b1, 1'b1, 64'hffff_fff9, 64'h2, 64'h0);
        chk(got.target[31:0], 64'hffff_fffd, "short quotient");
        chk(got.quotExt[31:0], 64'hffff_ffff, "short remainder");
        chk(got.wrQuotExt, 64'h1, "short remainder write");
        issue(IDU_XO_DIVS, 1'b0, 1'b0, 64'h8000_0000, 64'hffff_ffff, 64'h0);
        chk(got.target, 64'hffff_ffff_8000_0000, "short min quotient");
        chk(got.quotExt, 64'h0, "short min remainder");
        issue(IDU_XO_DIVX, 1'b0, 1'b0, 64'h0, 64'h2, 64'h1);
        chk({got.target[31:0], got.quotExt[31:0]}, 64'h1, "extended odd");
        issue(IDU_XO_DIVX, 1'b0, 1'b1, 64'h0, 64'h2, 64'h2);
        chk({got.target[31:0], got.quotExt[31:0]}, 64'h1_0000_0000, "extended even");
        issue(IDU_XO_DIVX, 1'b1, 1'b1, 64'hffff_ffff, 64'h2, 64'hffff_ffff);
        chk({got.target[31:0], got.quotExt[31:0]}, 64'hffff_ffff, "extended negative");
        issue(9'h000, 1'b1, 1'b1, 64'h4, 64'h2, 64'h0);
        chk(got.illegal, 64'h1, "unknown opcode");
        chk(got.updXer, 64'h0, "unknown opcode exception update");
        @(posedge ref_clk);
        is64BitImpl <= 1'b0;
        issue(IDU_XO_DIVD, 1'b1, 1'b1, 64'h4, 64'h2, 64'h0);
        chk(got.illegal, 64'h1, "signed on narrow core");
        issue(IDU_XO_DIVDU, 1'b0, 1'b0, 64'h4, 64'h2, 64'h0);
        chk(got.illegal, 64'h1, "unsigned on narrow core");
        print_verdict();
    end
endmodule
bind idu_divide_unit idu_divide_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .is64BitImpl(is64BitImpl),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp));
